// File: verilog/sktst_pkg.sv
// Purpose: Constants for the skip-test instruction logic
// Assumes: 10-bit instruction words, 4-bit data
// Notes: Flag-test and pin-test encodings are chosen values
// Function
// - Decode 0x026 as one-cycle acc-memory test
// - Skip when accumulator equals memory word
// - Enable low: flag set clears and skips
// - Enable high: flag test is no-operation
// - Enable is bit 0 of control reg a
// - Polarity zero: skip when pin low
// - Polarity is bit 2, one skips high
package sktst_pkg;
	localparam int INSTR_W = 10;
	localparam int DATA_W = 4;
	localparam logic [9:0] OP_SKIP_ACC_MEM = 10'h026;
	localparam logic [9:0] OP_SKIP_FLAG = 10'h03B;
	localparam logic [9:0] OP_SKIP_PIN = 10'h03A;
	localparam int EXT0_ENABLE_BIT = 0;
	localparam int EXT0_POL_BIT = 2;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [2:0] INT_EVENTS_RESET = 3'h0;
	localparam logic [1:0] REG_CTRL_A = 2'h0;
	localparam logic [1:0] REG_CTRL_B = 2'h1;
	localparam logic [1:0] REG_STATUS = 2'h2;
	localparam logic [1:0] REG_INT_EN = 2'h3;
	localparam logic [1:0] REG_INT_CLR = 2'h2;
endpackage

// File: verilog/sktst_sync.sv
// Purpose: Three-stage synchroniser for the interrupt pin
// Assumes: Pin is asynchronous to clk
// Notes: Level changes once stages two and three agree
`timescale 1ns/1ps
module sktst_sync (
	input wire logic clk,
	input wire logic resetn,
	input wire logic pin,
	output logic level
);
	logic s1_q, s2_q, s3_q;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
			level <= 1'b1;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level <= s3_q;
			end
		end
	end
endmodule

// File: verilog/sktst_core.sv
// Purpose: Skip-test instruction decode and execute
// Assumes: One instruction per clock; memory word supplied combinationally
// Notes: Registers reached by a plain strobe port
`timescale 1ns/1ps
module sktst_core (
	input wire logic clk,
	input wire logic resetn,
	input wire logic instr_valid,
	input wire logic [sktst_pkg::INSTR_W-1:0] instr,
	input wire logic [sktst_pkg::DATA_W-1:0] acc,
	input wire logic [sktst_pkg::DATA_W-1:0] mem_data,
	input wire logic carry_flag_in,
	input wire logic ext0_event,
	input wire logic ext_interrupt_pin_zero,
	input wire logic [1:0] addr,
	input wire logic [3:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [3:0] rdata,
	output logic skip_next,
	output logic suppress,
	output logic pc_advance,
	output logic carry_flag,
	output logic ext0_request_flag,
	output logic irq
);
	import sktst_pkg::*;
	logic [3:0] interrupt_control_reg_a_q;
	logic [3:0] interrupt_control_reg_b_q;
	logic [2:0] int_status_q;
	logic [2:0] int_en_q;
	logic pin_level;
	logic ext0_enable_bit;
	logic ext0_polarity_select;
	logic exec;
	logic is_acc_mem, is_flag, is_pin;
	logic take_acc, take_flag, take_pin, skip_d;
	logic flag_clear;

	sktst_sync u_sync (
		.clk(clk),
		.resetn(resetn),
		.pin(ext_interrupt_pin_zero),
		.level(pin_level)
	);

	// ==========================================================
	// Decode
	assign ext0_enable_bit =
		interrupt_control_reg_a_q[EXT0_ENABLE_BIT];
	assign ext0_polarity_select =
		interrupt_control_reg_b_q[EXT0_POL_BIT];
	assign exec = instr_valid && !skip_next;
	assign is_acc_mem = exec && instr == OP_SKIP_ACC_MEM;
	assign is_flag = exec && instr == OP_SKIP_FLAG;
	assign is_pin = exec && instr == OP_SKIP_PIN;
	assign take_acc = is_acc_mem && acc == mem_data;
	assign take_flag = is_flag && !ext0_enable_bit
		&& ext0_request_flag;
	assign take_pin = is_pin
		&& (pin_level == ext0_polarity_select);
	assign skip_d = take_acc || take_flag || take_pin;
	assign flag_clear = take_flag;

	// ==========================================================
	// Sequencing
	always_ff @(posedge clk) begin
		if (!resetn) begin
			skip_next <= 1'b0;
			suppress <= 1'b0;
			pc_advance <= 1'b0;
		end else if (instr_valid) begin
			skip_next <= skip_d;
			suppress <= skip_next;
			pc_advance <= 1'b1;
		end else begin
			pc_advance <= 1'b0;
			suppress <= 1'b0;
		end
	end

	// Carry passes through untouched
	always_ff @(posedge clk) begin
		if (!resetn) begin
			carry_flag <= 1'b0;
		end else begin
			carry_flag <= carry_flag_in;
		end
	end

	// ==========================================================
	// Request flag: set wins over clear
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ext0_request_flag <= 1'b0;
		end else if (ext0_event) begin
			ext0_request_flag <= 1'b1;
		end else if (flag_clear) begin
			ext0_request_flag <= 1'b0;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk) begin
		if (!resetn) begin
			interrupt_control_reg_a_q <= CTRL_RESET;
			interrupt_control_reg_b_q <= CTRL_RESET;
			int_en_q <= INT_EVENTS_RESET;
		end else if (wr) begin
			case (addr)
				REG_CTRL_A: interrupt_control_reg_a_q <= wdata;
				REG_CTRL_B: interrupt_control_reg_b_q <= wdata;
				REG_INT_EN: int_en_q <= wdata[2:0];
				default: ;
			endcase
		end
	end

	// Sticky events: bit0 acc skip, bit1 flag skip, bit2 pin skip
	always_ff @(posedge clk) begin
		if (!resetn) begin
			int_status_q <= INT_EVENTS_RESET;
		end else begin
			int_status_q <= (int_status_q
				& ~((wr && addr == REG_INT_CLR) ? wdata[2:0] : 3'h0))
				| {take_pin, take_flag, take_acc};
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_status_q & int_en_q);
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdata <= 4'h0;
		end else if (rd) begin
			case (addr)
				REG_CTRL_A: rdata <= interrupt_control_reg_a_q;
				REG_CTRL_B: rdata <= interrupt_control_reg_b_q;
				REG_STATUS: rdata <= {1'b0, int_status_q};
				REG_INT_EN: rdata <= {1'b0, int_en_q};
				default: rdata <= 4'h0;
			endcase
		end else begin
			rdata <= 4'h0;
		end
	end

	// ==========================================================
	// Assertions
	acc_skip_a: assert property (
		@(posedge clk) disable iff (!resetn)
		take_acc |=> skip_next)
		else $error("equal compare did not skip");

	acc_noskip_a: assert property (
		@(posedge clk) disable iff (!resetn)
		(is_acc_mem && acc != mem_data) |=> !skip_next)
		else $error("unequal compare skipped");

	flag_clear_a: assert property (
		@(posedge clk) disable iff (!resetn)
		(take_flag && !ext0_event) |=> !ext0_request_flag)
		else $error("request flag not cleared");

	flag_nop_a: assert property (
		@(posedge clk) disable iff (!resetn)
		(is_flag && ext0_enable_bit && !ext0_event)
		|=> (!skip_next && $stable(ext0_request_flag)))
		else $error("disabled flag test acted");

	flag_gate_a: assert property (
		@(posedge clk) disable iff (!resetn)
		(wr && addr == REG_CTRL_A)
		|=> (ext0_enable_bit == $past(wdata[0])))
		else $error("flag enable not taken from bit zero");

	pin_low_a: assert property (
		@(posedge clk) disable iff (!resetn)
		(is_pin && !ext0_polarity_select && !pin_level)
		|=> skip_next)
		else $error("low pin did not skip");

	pin_high_a: assert property (
		@(posedge clk) disable iff (!resetn)
		(is_pin && interrupt_control_reg_b_q[2] && !pin_level)
		|=> !skip_next)
		else $error("polarity one skipped on low");

	pol_bit_a: assert property (
		@(posedge clk) disable iff (!resetn)
		(wr && addr == REG_CTRL_B)
		|=> (ext0_polarity_select == $past(wdata[2])))
		else $error("polarity not taken from bit two");

	skip_suppress_a: assert property (
		@(posedge clk) disable iff (!resetn)
		(skip_next && instr_valid)
		|=> (suppress && !skip_next && pc_advance))
		else $error("skipped word not suppressed");

	quiet_skip_a: assert property (
		@(posedge clk) disable iff (!resetn)
		(skip_next && instr_valid && ext0_request_flag)
		|=> ext0_request_flag)
		else $error("suppressed word cleared the flag");

	pc_step_a: assert property (
		@(posedge clk) disable iff (!resetn)
		instr_valid |=> pc_advance)
		else $error("program counter did not advance");

	carry_keep_a: assert property (
		@(posedge clk) disable iff (!resetn)
		is_acc_mem |=> carry_flag == $past(carry_flag_in))
		else $error("carry altered");

	flag_set_a: assert property (
		@(posedge clk) disable iff (!resetn)
		ext0_event |=> ext0_request_flag)
		else $error("request event lost");

	rdata_idle_a: assert property (
		@(posedge clk) disable iff (!resetn)
		!rd |=> (rdata == 4'h0))
		else $error("read data outside read slot");

	// ==========================================================
	// Coverage of the main scenarios
	acc_skip_c: cover property (@(posedge clk) disable iff (!resetn)
		take_acc);
	flag_skip_c: cover property (@(posedge clk) disable iff (!resetn)
		take_flag);
	pin_skip_c: cover property (@(posedge clk) disable iff (!resetn)
		take_pin ##1 skip_next);
	flag_nop_c: cover property (@(posedge clk) disable iff (!resetn)
		is_flag && ext0_enable_bit);
	pin_pol_c: cover property (@(posedge clk) disable iff (!resetn)
		take_pin && ext0_polarity_select);
endmodule

// File: tb/testbench.sv
// Purpose: Self-checking bench for the skip-test instruction logic
// Assumes: 10 MHz clock, synchronous active-low reset
// Notes: Random operands from a fixed seed plus corner cases
`timescale 1ns/1ps
module testbench;
	import sktst_pkg::*;
	logic clk, resetn, instr_valid, cyi, ev, pin, wr, rd;
	logic [9:0] instr;
	logic [3:0] acc, mem_data, wdata, rdata, a, m;
	logic [1:0] addr;
	logic skip_next, suppress, pc_advance, carry_flag, flag, irq;
	int miscompares = 0, tests_run = 0, cycles = 0;
	sktst_core sktst_core_i (.clk(clk), .resetn(resetn),
		.instr_valid(instr_valid), .instr(instr), .acc(acc),
		.mem_data(mem_data), .carry_flag_in(cyi), .ext0_event(ev),
		.ext_interrupt_pin_zero(pin), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .skip_next(skip_next), .suppress(suppress),
		.pc_advance(pc_advance), .carry_flag(carry_flag),
		.ext0_request_flag(flag), .irq(irq));
	// ==========================================
	// Clock, timeout and helpers
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			final_report();
		end
	end
	function automatic logic pin_skip(logic pol, logic lvl);
		return pol ? lvl : ~lvl;
	endfunction
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(string n, logic [3:0] e, logic [3:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic exec(logic [9:0] w);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr <= w;
		@(posedge clk);
		instr_valid <= 1'b0;
		#1;
		chk("pc_advance", 4'h1, {3'h0, pc_advance});
	endtask
	task automatic test(logic [9:0] w, logic s);
		exec(w);
		chk("skip_next", {3'h0, s}, {3'h0, skip_next});
		exec(10'h000);
		chk("suppress", {3'h0, s}, {3'h0, suppress});
	endtask
	task automatic wreg(logic [1:0] ad, logic [3:0] d);
		@(posedge clk);
		addr <= ad;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(logic [1:0] ad, logic [3:0] e);
		@(posedge clk);
		addr <= ad;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk("rdata", e, rdata);
	endtask
	task automatic pulse();
		@(posedge clk);
		ev <= 1'b1;
		@(posedge clk);
		ev <= 1'b0;
	endtask
	task automatic irq_is(logic e);
		repeat (2) @(posedge clk);
		#1;
		chk("irq", {3'h0, e}, {3'h0, irq});
	endtask
	// ==========================================
	// Main sequence
	initial begin
		{resetn, instr_valid, cyi, ev, wr, rd} = '0;
		{instr, acc, mem_data, addr, wdata} = '0;
		pin = 1'b1;
		void'($urandom(32'hC147));
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 40; i++) begin
			a = 4'($urandom);
			m = (i % 4 == 0) ? a : 4'($urandom);
			acc <= a;
			mem_data <= m;
			cyi <= i[0];
			test(OP_SKIP_ACC_MEM, a == m);
			chk("carry_flag", {3'h0, i[0]}, {3'h0, carry_flag});
		end
		wreg(REG_INT_CLR, 4'h7);
		wreg(REG_INT_EN, 4'h1);
		irq_is(1'b0);
		acc <= 4'hF;
		mem_data <= 4'hF;
		test(OP_SKIP_ACC_MEM, 1'b1);
		irq_is(1'b1);
		rreg(REG_STATUS, 4'h1);
		wreg(REG_INT_EN, 4'h0);
		irq_is(1'b0);
		wreg(REG_INT_EN, 4'h1);
		wreg(REG_INT_CLR, 4'h1);
		irq_is(1'b0);
		wreg(REG_CTRL_A, 4'hE);
		pulse();
		test(OP_SKIP_FLAG, 1'b1);
		chk("flag", 4'h0, {3'h0, flag});
		test(OP_SKIP_FLAG, 1'b0);
		exec(OP_SKIP_ACC_MEM);
		pulse();
		exec(OP_SKIP_FLAG);
		chk("suppress", 4'h1, {3'h0, suppress});
		chk("flag", 4'h1, {3'h0, flag});
		chk("skip_next", 4'h0, {3'h0, skip_next});
		wreg(REG_CTRL_A, 4'h1);
		test(OP_SKIP_FLAG, 1'b0);
		chk("flag", 4'h1, {3'h0, flag});
		rreg(REG_CTRL_A, 4'h1);
		rreg(REG_STATUS, 4'h3);
		for (int k = 0; k < 4; k++) begin
			wreg(REG_CTRL_B, {1'b1, k[1], 2'b11});
			pin <= k[0];
			repeat (6) @(posedge clk);
			test(OP_SKIP_PIN, pin_skip(k[1], k[0]));
		end
		rreg(REG_CTRL_B, 4'hF);
		rreg(REG_STATUS, 4'h7);
		rreg(REG_INT_EN, 4'h1);
		final_report();
	end
endmodule
